// ===== design/rs_fec_map.svh
// Offsets, field values, reset values and counts of the FEC decoder
`ifndef RS_FEC_MAP_SVH
`define RS_FEC_MAP_SVH
`define BLK_LEN     12'h0CC
`define LAST_IDX    8'hCB
`define LAST_DATA   8'hBB
`define FIRST_PAR   8'hBC
`define LAST_BRANCH 4'hB
`define NUM_BRANCH  4'hC
`define FILL_BLKS   4'hB
`define NUM_SYN     16
`define SYNC_FRAME  8'hB8
`define SYNC_BLOCK  8'h47
`define GF_POLY     8'h1D
`define GF_ALPHA    8'h02
`define I2C_ADDR    7'h69
`define CNT_MAX     23'h7FFFFF
`define CNT_BLK_PEN 23'h000009
`define PRBS_INIT   15'h00A9
`define DIR_RST     6'h3F
`define BCLK_HALF   2'h2
`endif

// ===== design/rs_fec_pkg.sv
// Types shared by the FEC decoder: state enums and the state record
package rs_fec_pkg;
    typedef enum logic [2:0] {
        SY_HUNT, SY_1, SY_2, SY_3, SY_4, SY_5, SY_LOCK
    } sync_e;
    typedef enum logic [2:0] {
        I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK
    } i2c_e;
    typedef struct packed {
        sync_e             sst;
        logic [8:0]        sh;
        logic              odd;
        logic [1:0]        bc;
        logic [7:0]        idx;
        logic [3:0]        br;
        logic [3:0]        wblk;
        logic [3:0]        fill;
        logic              bv;
        logic              wbuf;
        logic [15:0][7:0]  syn;
        logic [15:0][7:0]  sl;
        logic              lvalid;
        logic [7:0]        t;
        logic [2:0]        fcnt;
        logic              flock;
        logic [14:0]       prbs;
        logic              uncor;
        logic              chk;
        logic [22:0]       cnt;
        logic [1:0]        bt;
        logic [7:0]        oidx;
        logic [7:0]        dout;
        logic              bclk;
        logic              bgn;
        logic              blk_err;
        logic              unsynced;
    } dp_s;
    typedef struct packed {
        dp_s               dp;
        logic              srst;
        logic [2:0]        sclq;
        logic [2:0]        sdaq;
        logic [2:0][5:0]   prtq;
        logic              sclf;
        logic              sdaf;
        logic [5:0]        pinf;
        i2c_e              ist;
        logic [3:0]        ibit;
        logic [7:0]        ish;
        logic              rw;
        logic [1:0]        bidx;
        logic [23:0]       snap;
        logic [5:0]        plat;
        logic [5:0]        poe;
        logic              flag_en;
        logic              sda_oe;
        logic              sdo;
    } st_s;
endpackage

// ===== design/rs_fec_decoder.sv
// DVB cable FEC back end: sync, de-interleave, RS decode, descramble, I2C
// Notes on behaviour
// - Blocks are 204 bytes, one sync byte first
// - Eight-block frames: B8H first, 47H for others
// - Block sync machine steps states zero to six
// - Corrected B8H block start resyncs frame counter
// - Not-synced output low after six consecutive syncs
// - Block error rises at begin, drops if good and frame locked
// - Byte N delayed (203-N) mod 12 blocks
// - Syndrome, locator solve, search-and-value pipelined units
// - Code roots alpha^0..15 over x^8+x^4+x^3+x^2+1
// - Correct only correctable blocks, else pass unchanged
// - Flag enabled: set error bit in bad blocks
// - Parity bytes dropped: zero output, byte clock stopped
// - 15-bit descrambler reset per frame; syncs untouched
// - One byte per byte clock edge; begin marks first
// - Block error high on bad blocks or before frame lock, else low
// - I2C slave at address 1101001, bit selects direction
// - Write bytes: port data, then flag and direction
// - Second write byte resets the decoder
// - Flag enable and directions default to ones
// - Read: port levels, sync plus count, count bytes
// - Count +1 per fixed byte, +9 per bad block
// - Count cleared by resets or fourth read byte
`timescale 1ns/1ps
`include "rs_fec_map.svh"
module rs_fec_decoder (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic [1:0]  data_in,
    input  wire logic        input_valid,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic [5:0]  port_in,
    output logic      [5:0]  port_out,
    output logic      [5:0]  port_oe,
    output logic      [7:0]  byte_out,
    output logic             byte_clock_out,
    output logic             block_begin_out,
    output logic             block_error_out,
    output logic             not_synchronized_out
);
    // GF(256) product, shift-and-add with the field polynomial
    function automatic logic [7:0] gf_mul(input logic [7:0] a,
                                          input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) p = p ^ x;
            x = x[7] ? ({x[6:0], 1'b0} ^ `GF_POLY) : {x[6:0], 1'b0};
        end
        return p;
    endfunction

    function automatic logic [7:0] gf_pow(input int e);
        logic [7:0] p;
        p = 8'h01;
        for (int i = 0; i < e; i++) begin
            p = gf_mul(p, `GF_ALPHA);
        end
        return p;
    endfunction

    function automatic logic is_sync(input logic [7:0] b);
        return (b == `SYNC_BLOCK) || (b == `SYNC_FRAME);
    endfunction

    // Eight descrambler steps: mask in top byte, new state below
    function automatic logic [22:0] prbs8(input logic [14:0] p);
        logic [14:0] q;
        logic [7:0]  m;
        logic        b;
        q = p;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            b = q[13] ^ q[14];
            m = {m[6:0], b};
            q = {q[13:0], b};
        end
        return {m, q};
    endfunction

    localparam logic [7:0] A203 = gf_pow(203);
    localparam logic [7:0] AINV = gf_pow(254);

    rs_fec_pkg::st_s   s;
    rs_fec_pkg::st_s   n;
    logic [7:0]        dmem [0:2447];
    logic [7:0]        rbuf [0:407];
    logic [15:0][7:0]  syn_upd;
    logic [15:0]       nz;
    logic [13:0]       geo;
    logic              zero;
    logic              single;
    logic              good;
    logic              hunt;
    logic              got;
    logic              hit;
    logic              cnt_clr;
    logic              rise;
    logic              fall;
    logic [8:0]        sh2;
    logic [7:0]        ci;
    logic [7:0]        inb;
    logic [7:0]        dint;
    logic [7:0]        raw;
    logic [7:0]        cor;
    logic [7:0]        fin;
    logic [7:0]        tcur;
    logic [7:0]        txb;
    logic [3:0]        cb;
    logic [3:0]        rb;
    logic [2:0]        fc;
    logic [5:0]        agree;
    logic [11:0]       waddr;
    logic [11:0]       raddr;
    logic [8:0]        bwaddr;
    logic [8:0]        braddr;
    logic [22:0]       pr;
    logic [22:0]       inc;
    logic [23:0]       sum;

    // Syndrome Horner steps and single-error consistency checks
    for (genvar j = 0; j < `NUM_SYN; j++) begin : g_syn
        localparam logic [7:0] ROOT = gf_pow(j);
        assign syn_upd[j] = gf_mul(s.dp.syn[j], ROOT);
        assign nz[j] = (s.dp.sl[j] != 8'h00);
    end
    for (genvar j = 0; j < `NUM_SYN - 2; j++) begin : g_geo
        assign geo[j] = gf_mul(s.dp.sl[j], s.dp.sl[j + 2])
                     == gf_mul(s.dp.sl[j + 1], s.dp.sl[j + 1]);
    end
    assign zero   = (s.dp.sl == '0);
    assign single = (&geo) && (&nz);
    assign good   = s.dp.lvalid && (zero || single);

    // Next-state logic for the whole decoder
    always_comb begin
        n = s;
        n.srst = 1'b0;
        cnt_clr = 1'b0;
        hit = 1'b0;
        got = 1'b0;
        inb = 8'h00;
        fin = 8'h00;
        inc = 23'h000000;
        hunt = (s.dp.sst == rs_fec_pkg::SY_HUNT);
        sh2 = {s.dp.sh[6:0], data_in};
        ci = hunt ? 8'h00 : s.dp.idx;
        cb = hunt ? `LAST_BRANCH : s.dp.br;
        // Byte alignment: in hunt try both bit phases of the pair
        if (input_valid) begin
            n.dp.sh = sh2;
            n.dp.bc = s.dp.bc + 2'h1;
            if (hunt) begin
                n.dp.bc = 2'h0;
                if (is_sync(sh2[7:0])) begin
                    got = 1'b1;
                    n.dp.odd = 1'b0;
                end else if (is_sync(sh2[8:1])) begin
                    got = 1'b1;
                    n.dp.odd = 1'b1;
                end
            end else begin
                got = (s.dp.bc == 2'h3);
            end
            inb = (n.dp.odd) ? sh2[8:1] : sh2[7:0];
        end
        // Block position counter and de-interleave branch
        rb = (s.dp.wblk >= cb) ? s.dp.wblk - cb
                               : s.dp.wblk + `NUM_BRANCH - cb;
        waddr = 12'(s.dp.wblk) * `BLK_LEN + 12'(ci);
        raddr = 12'(rb) * `BLK_LEN + 12'(ci);
        bwaddr = 9'(s.dp.wbuf) * 9'(`BLK_LEN) + 9'(ci);
        // Other half of the ping-pong buffer; a cast of ~wbuf would widen
        braddr = (s.dp.wbuf ? 9'h000 : 9'(`BLK_LEN)) + 9'(ci);
        dint = (cb == 4'h0) ? inb : dmem[raddr];
        raw = rbuf[braddr];
        tcur = (ci == 8'h00) ? gf_mul(s.dp.sl[0], A203) : s.dp.t;
        cor = raw;
        pr = prbs8(s.dp.prbs);
        fc = s.dp.fcnt;
        // Byte clock half period: rises two cycles after new data
        if (s.dp.bt != 2'h0) begin
            n.dp.bt = s.dp.bt - 2'h1;
            if (s.dp.bt == 2'h1) n.dp.bclk = 1'b1;
        end
        // One cycle after begin the block error may drop
        if (s.dp.chk) begin
            n.dp.chk = 1'b0;
            n.dp.blk_err = s.dp.uncor || !s.dp.flock;
        end
        if (got) begin
            n.dp.idx = (ci == `LAST_IDX) ? 8'h00 : ci + 8'h01;
            n.dp.br = (cb == 4'h0) ? `LAST_BRANCH : cb - 4'h1;
            if (ci == 8'h00) begin
                // Block sync machine, evaluated on each sync position
                if (is_sync(inb)) begin
                    n.dp.sst = (s.dp.sst == rs_fec_pkg::SY_LOCK)
                             ? rs_fec_pkg::SY_LOCK
                             : rs_fec_pkg::sync_e'(s.dp.sst + 3'h1);
                end else begin
                    n.dp.sst = (s.dp.sst == rs_fec_pkg::SY_LOCK)
                             ? rs_fec_pkg::SY_5 : rs_fec_pkg::SY_HUNT;
                end
                // Lock is not trusted until the delay lines are full
                if (n.dp.sst != rs_fec_pkg::SY_LOCK) n.dp.fill = 4'h0;
                n.dp.bv = (n.dp.sst == rs_fec_pkg::SY_LOCK)
                       && (s.dp.fill == `FILL_BLKS);
            end
            if (ci == `LAST_IDX) begin
                n.dp.wblk = (s.dp.wblk == `LAST_BRANCH) ? 4'h0
                          : s.dp.wblk + 4'h1;
                if (s.dp.sst == rs_fec_pkg::SY_LOCK
                    && s.dp.fill != `FILL_BLKS) n.dp.fill = s.dp.fill + 4'h1;
                n.dp.wbuf = ~s.dp.wbuf;
                n.dp.lvalid = s.dp.bv;
            end
            // Syndrome unit accumulates the de-interleaved block
            for (int j = 0; j < `NUM_SYN; j++) begin
                n.dp.syn[j] = ((ci == 8'h00) ? 8'h00 : syn_upd[j]) ^ dint;
                if (ci == `LAST_IDX) n.dp.sl[j] = n.dp.syn[j];
            end
            // Search for the error position, one step per byte
            hit = single && s.dp.lvalid && (tcur == s.dp.sl[1]);
            n.dp.t = gf_mul(tcur, AINV);
            if (hit) cor = raw ^ s.dp.sl[0];
            if (hit) inc = 23'h000001;
            fin = cor;
            if (ci == 8'h00) begin
                // Frame counter runs free, resynced by a good B8H
                if (good && cor == `SYNC_FRAME) begin
                    fc = 3'h0;
                    n.dp.flock = 1'b1;
                end else begin
                    fc = s.dp.fcnt + 3'h1;
                    if (!s.dp.lvalid) n.dp.flock = 1'b0;
                end
                n.dp.fcnt = fc;
                n.dp.prbs = (fc == 3'h0) ? `PRBS_INIT : pr[14:0];
                n.dp.uncor = !good;
                n.dp.blk_err = 1'b1;
                n.dp.chk = 1'b1;
                if (!good) inc = `CNT_BLK_PEN;
            end else if (ci <= `LAST_DATA) begin
                if (s.dp.flock) fin = cor ^ pr[22:15];
                n.dp.prbs = pr[14:0];
                if (ci == 8'h01 && s.flag_en && s.dp.uncor)
                    fin[7] = 1'b1;
            end
            // Output byte bus; parity positions give zero, no clock
            n.dp.oidx = ci;
            n.dp.bclk = 1'b0;
            n.dp.bgn = (ci == 8'h00);
            if (ci >= `FIRST_PAR) begin
                n.dp.dout = 8'h00;
                n.dp.bt = 2'h0;
            end else begin
                n.dp.dout = fin;
                n.dp.bt = `BCLK_HALF;
            end
        end
        n.dp.unsynced = (n.dp.sst != rs_fec_pkg::SY_LOCK);
        // Pin filters: a level counts once second and third stages agree
        n.sclq = {s.sclq[1:0], scl_in};
        n.sdaq = {s.sdaq[1:0], sda_in};
        n.prtq = {s.prtq[1:0], port_in};
        if (s.sclq[1] == s.sclq[2]) n.sclf = s.sclq[2];
        if (s.sdaq[1] == s.sdaq[2]) n.sdaf = s.sdaq[2];
        agree = ~(s.prtq[1] ^ s.prtq[2]);
        n.pinf = (agree & s.prtq[2]) | (~agree & s.pinf);
        rise = !s.sclf && n.sclf;
        fall = s.sclf && !n.sclf;
        unique case (s.bidx)
            2'h0: txb = {2'b00, s.pinf};
            2'h1: txb = s.snap[23:16];
            2'h2: txb = s.snap[15:8];
            2'h3: txb = s.snap[7:0];
        endcase
        // I2C slave; start and stop conditions override the bit engine
        if (s.sclf && n.sclf && s.sdaf && !n.sdaf) begin
            n.ist = rs_fec_pkg::I_ADDR;
            n.ibit = 4'h0;
            n.sda_oe = 1'b0;
        end else if (s.sclf && n.sclf && !s.sdaf && n.sdaf) begin
            n.ist = rs_fec_pkg::I_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            unique case (s.ist)
                rs_fec_pkg::I_IDLE: begin
                end
                rs_fec_pkg::I_ADDR, rs_fec_pkg::I_WR: begin
                    if (rise) begin
                        n.ish = {s.ish[6:0], s.sdaf};
                        n.ibit = s.ibit + 4'h1;
                    end
                    if (fall && s.ibit == 4'h8) begin
                        n.ibit = 4'h0;
                        n.sda_oe = 1'b1;
                        if (s.ist == rs_fec_pkg::I_WR) begin
                            n.ist = rs_fec_pkg::I_WACK;
                            if (s.bidx != 2'h2) n.bidx = s.bidx + 2'h1;
                            if (s.bidx == 2'h0) n.plat = s.ish[5:0];
                            if (s.bidx == 2'h1) begin
                                n.flag_en = s.ish[7];
                                n.poe = ~s.ish[5:0];
                                n.srst = 1'b1;
                            end
                        end else if (s.ish[7:1] == `I2C_ADDR) begin
                            n.ist = rs_fec_pkg::I_AACK;
                            n.rw = s.ish[0];
                            n.bidx = 2'h0;
                            n.snap = {s.dp.unsynced, s.dp.cnt};
                        end else begin
                            n.ist = rs_fec_pkg::I_IDLE;
                            n.sda_oe = 1'b0;
                        end
                    end
                end
                rs_fec_pkg::I_AACK, rs_fec_pkg::I_RACK: begin
                    if (rise && s.ist == rs_fec_pkg::I_RACK && s.sdaf)
                        n.ist = rs_fec_pkg::I_IDLE;
                    else if (fall && s.rw) begin
                        n.ist = rs_fec_pkg::I_RD;
                        n.ish = txb;
                        n.sda_oe = ~txb[7];
                        n.ibit = 4'h0;
                    end else if (fall) begin
                        n.ist = rs_fec_pkg::I_WR;
                        n.sda_oe = 1'b0;
                    end
                end
                rs_fec_pkg::I_WACK: begin
                    if (fall) begin
                        n.ist = rs_fec_pkg::I_WR;
                        n.sda_oe = 1'b0;
                    end
                end
                rs_fec_pkg::I_RD: begin
                    if (rise) n.ibit = s.ibit + 4'h1;
                    if (fall && s.ibit == 4'h8) begin
                        n.ist = rs_fec_pkg::I_RACK;
                        n.sda_oe = 1'b0;
                        cnt_clr = (s.bidx == 2'h3);
                        n.bidx = s.bidx + 2'h1;
                    end else if (fall) begin
                        n.ish = {s.ish[6:0], 1'b0};
                        n.sda_oe = ~s.ish[6];
                    end
                end
            endcase
        end
        // Error tally saturates; a new event wins over the read clear
        sum = 24'(cnt_clr ? 23'h000000 : s.dp.cnt) + 24'(inc);
        n.dp.cnt = (sum > 24'(`CNT_MAX)) ? `CNT_MAX : sum[22:0];
        // Software reset clears the datapath but keeps the control bytes
        if (s.srst) begin
            n.dp = '0;
            n.dp.unsynced = 1'b1;
            n.dp.blk_err = 1'b1;
        end
    end

    // State register; hardware reset restores control defaults
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s <= '0;
            s.dp.unsynced <= 1'b1;
            s.dp.blk_err <= 1'b1;
            s.flag_en <= 1'b1;
            s.poe <= ~`DIR_RST;
            s.sclq <= 3'h7;
            s.sdaq <= 3'h7;
            s.sclf <= 1'b1;
            s.sdaf <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // Delay lines and block buffer; no reset, filled before use
    always_ff @(posedge ref_clk) begin
        if (got) begin
            dmem[waddr] <= inb;
            rbuf[bwaddr] <= dint;
        end
    end

    assign sda_out              = s.sdo;
    assign sda_oe               = s.sda_oe;
    assign port_out             = s.plat;
    assign port_oe              = s.poe;
    assign byte_out             = s.dp.dout;
    assign byte_clock_out       = s.dp.bclk;
    assign block_begin_out      = s.dp.bgn;
    assign block_error_out      = s.dp.blk_err;
    assign not_synchronized_out = s.dp.unsynced;

    default clocking cb_main @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    AST_NOT_SYNCED_MATCH: assert property (
        (s.dp.sst == rs_fec_pkg::SY_LOCK) == !not_synchronized_out)
        else $error("not-synced output disagrees with lock");
    AST_BLOCK_ERR_AT_BEGIN: assert property (
        $rose(block_begin_out) |-> block_error_out)
        else $error("block error low at block begin");
    AST_BLOCK_ERR_DROP: assert property (
        $rose(block_begin_out) && !s.dp.uncor && s.dp.flock
        |=> !block_error_out)
        else $error("block error did not drop on good block");
    AST_PARITY_QUIET: assert property (
        s.dp.oidx >= `FIRST_PAR |-> byte_out == 8'h00 && !byte_clock_out)
        else $error("output active during parity bytes");
    AST_BEGIN_FIRST: assert property (
        block_begin_out |-> s.dp.oidx == 8'h00)
        else $error("begin outside first byte");
    AST_BCLK_STABLE: assert property (
        $rose(byte_clock_out) |-> $stable(byte_out))
        else $error("data changed at byte clock edge");
    AST_BCLK_RISE: assert property (
        $fell(byte_clock_out) && !$past(s.srst) && s.dp.oidx < `FIRST_PAR
        |-> ##2 byte_clock_out)
        else $error("byte clock did not rise two cycles on");
    AST_CNT_SAT: assert property (
        $past(s.dp.cnt) == `CNT_MAX && !$past(cnt_clr) && !$past(s.srst)
        |-> s.dp.cnt == `CNT_MAX)
        else $error("error tally left saturation");
    AST_SRST_CLEAR: assert property (
        s.srst |=> s.dp.cnt == 23'h000000 && not_synchronized_out)
        else $error("software reset did not clear");
    AST_HW_DEFAULT: assert property (
        $past(sys_rst) |-> port_oe == ~`DIR_RST && s.flag_en)
        else $error("control defaults wrong after reset");
    AST_ADDR_ACK: assert property (
        s.ist == rs_fec_pkg::I_AACK |-> sda_oe)
        else $error("address not acknowledged");

    COV_LOCK: cover property ($fell(not_synchronized_out));
    COV_FIX: cover property (hit);
    COV_READ4: cover property (cnt_clr);
    COV_SRST: cover property (s.srst);
endmodule

// ===== verification/stream_source.sv
// Demodulator stand-in: framed blocks, two bits on every other clock
`timescale 1ns/1ps
`include "rs_fec_map.svh"
module stream_source (
    input  wire logic       ref_clk,
    input  wire logic       run,
    output logic      [1:0] data_in = 2'h0,
    output logic            input_valid = 1'b0
);
    logic [7:0] idx = 8'h00;
    logic [2:0] blk = 3'h0;
    logic [1:0] pair = 2'h0;
    logic [7:0] cur;
    // Zero payload, so no false sync pattern appears on either bit phase
    assign cur = (idx != 8'h00) ? 8'h00
               : (blk == 3'h0) ? `SYNC_FRAME : `SYNC_BLOCK;
    // Idle clocks carry a changing pattern that must be ignored
    always @(posedge ref_clk) begin
        #1;
        if (run && !input_valid) begin
            input_valid = 1'b1;
            data_in = cur[7 - 2 * pair -: 2];
            pair = pair + 2'h1;
            if (pair == 2'h0) begin
                idx = (idx == `LAST_IDX) ? 8'h00 : idx + 8'h01;
                if (idx == 8'h00) blk = blk + 3'h1;
            end
        end else begin
            input_valid = 1'b0;
            data_in = ~data_in;
        end
    end
endmodule

// ===== verification/dvb_reed_solomon_fec_decoder_bench.sv
// Self-checking bench of the FEC decoder: lock, I2C control, read-back
`timescale 1ns/1ps
`include "rs_fec_map.svh"
`define CHECK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module dvb_reed_solomon_fec_decoder_bench;
    typedef struct packed {
        logic [7:0] b1;
        logic [7:0] b2;
        logic [5:0] pout;
        logic [5:0] poe;
    } row_s;
    localparam int H = 8;
    row_s        rows [2] = '{'{8'h15, 8'h80, 6'h15, 6'h3F},
                              '{8'h2A, 8'h3C, 6'h2A, 6'h03}};
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        run = 1'b0;
    logic        scl_in = 1'b1;
    logic        sda_host = 1'b1;
    logic [5:0]  port_in = 6'h2D;
    logic [1:0]  data_in;
    logic        input_valid, sda_in, sda_out, sda_oe, byte_clock_out;
    logic        block_begin_out, block_error_out, not_synchronized_out;
    logic [5:0]  port_out, port_oe;
    logic [7:0]  byte_out;
    logic [8:0]  q;
    logic [31:0] v;
    int          errors = 0, compares = 0, cycles = 0;
    // Open-drain data line with pull-up: low whenever anyone pulls it
    assign sda_in = sda_oe ? sda_out : sda_host;
    always #2 ref_clk = ~ref_clk;
    stream_source src_u (.ref_clk(ref_clk), .run(run), .data_in(data_in),
        .input_valid(input_valid));
    rs_fec_decoder dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .data_in(data_in), .input_valid(input_valid), .scl_in(scl_in),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
        .byte_out(byte_out), .byte_clock_out(byte_clock_out),
        .block_begin_out(block_begin_out),
        .block_error_out(block_error_out),
        .not_synchronized_out(not_synchronized_out));
    task automatic stop_test();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // SDA moves only mid-low of SCL, so no false start or stop is seen
    task automatic xfer(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            tick(4);
            sda_host = d[i];
            tick(H);
            scl_in = 1'b1;
            tick(H);
            r[i] = sda_in;
            scl_in = 1'b0;
        end
    endtask
    task automatic i2c_start();
        sda_host = 1'b1;
        scl_in = 1'b1;
        tick(H);
        sda_host = 1'b0;
        tick(H);
        scl_in = 1'b0;
    endtask
    task automatic i2c_stop();
        tick(4);
        sda_host = 1'b0;
        tick(H);
        scl_in = 1'b1;
        tick(H);
        sda_host = 1'b1;
        tick(H);
    endtask
    // Four read bytes, master acks all but the last
    task automatic read4(output logic [31:0] w);
        i2c_start();
        xfer({`I2C_ADDR, 1'b1, 1'b1}, q);
        `CHECK("read ack", 1'b0, q[0])
        for (int i = 3; i >= 0; i--) begin
            xfer({8'hFF, i == 0}, q);
            w[i * 8 +: 8] = q[8:1];
        end
        i2c_stop();
    endtask
    initial begin
        tick(20);
        `CHECK("not_sync", 1'b1, not_synchronized_out)
        `CHECK("block_error", 1'b1, block_error_out)
        `CHECK("port_oe", 6'h00, port_oe)
        `CHECK("byte_clock", 1'b0, byte_clock_out)
        sys_rst = 1'b0;
        run = 1'b1;
        tick(15000);
        `CHECK("not_sync", 1'b0, not_synchronized_out)
        foreach (rows[k]) begin
            i2c_start();
            xfer({`I2C_ADDR, 1'b0, 1'b1}, q);
            `CHECK("addr ack", 1'b0, q[0])
            xfer({rows[k].b1, 1'b1}, q);
            xfer({rows[k].b2, 1'b1}, q);
            `CHECK("ctrl ack", 1'b0, q[0])
            i2c_stop();
            `CHECK("port_out", rows[k].pout, port_out)
            `CHECK("port_oe", rows[k].poe, port_oe)
            `CHECK("not_sync", 1'b1, not_synchronized_out)
        end
        i2c_start();
        xfer({7'h68, 1'b0, 1'b1}, q);
        i2c_stop();
        `CHECK("foreign addr", 1'b1, q[0])
        run = 1'b0;
        sys_rst = 1'b1;
        tick(5);
        sys_rst = 1'b0;
        tick(8);
        read4(v);
        `CHECK("read bytes", {2'b00, port_in, 1'b1, 23'h0}, v)
        run = 1'b1;
        tick(8000);
        run = 1'b0;
        tick(20);
        read4(v);
        `CHECK("count", 1'b1, v[22:0] % 9 == 0 && v[22:0] != 0)
        read4(v);
        `CHECK("count cleared", 23'h0, v[22:0])
        stop_test();
    end
    // A hang counts as a mismatch
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 50000) begin
            errors++;
            stop_test();
        end
    end
endmodule
